// file: rtl/dch_channel.sv
// one dma channel: peripheral control line, done, transfer complete strobe,
// auto-request generation and priority arbitration against peer channels
// assumes a bus-cycle engine on clk_i that reports cycle phases as pulses/levels
`timescale 1ns/10ps
`default_nettype none
`include "dch_params.svh"
module dch_channel #(
    parameter int NPEER = 3
) (
    input wire logic clk_i,                      // 20 MHz clock
    input wire logic reset_i,                    // synchronous reset, high
    input wire logic [2:0] reg_addr_i,           // register address
    input wire logic [7:0] reg_wdata_i,          // write data
    input wire logic reg_wr_i,                   // write strobe
    input wire logic reg_rd_i,                   // read strobe
    output logic [7:0] reg_rdata_o,              // read data, cycle after read
    input wire logic pcl_n_i,                    // control line level in
    output logic pcl_n_o,                        // control line drive value
    output logic pcl_oe_o,                       // control line drive enable
    input wire logic done_n_i,                   // done line level in
    output logic done_n_o,                       // done drive value
    output logic done_oe_o,                      // done drive enable
    input wire logic bus_grant_acknowledge_n_i,                  // bus grant acknowledge pin
    output logic ack_n_o,                        // acknowledge out
    output logic high_byte_indicator_n_o,                      // high byte indicator out
    output logic dtc_n_o,                        // transfer complete strobe
    output logic irq_o,                          // interrupt request
    output logic eclk_rise_o,                    // enable clock rising pulse
    output logic eclk_fall_o,                    // enable clock falling pulse
    output logic ready_o,                        // peripheral ready level
    input wire logic cyc_dev_i,                  // engine: peripheral cycle in progress
    input wire logic cyc_high_byte_indicator_i,                // engine: high byte cycle
    input wire logic cyc_mtc_last_i,             // engine: memory count reaches zero
    input wire logic cyc_btc_last_i,             // engine: last chained block
    input wire logic cyc_data_i,                 // engine: data or chain-read cycle
    input wire logic cyc_exc_i,                  // engine: cycle ended by exception
    input wire logic cyc_strobe_i,               // engine: data strobe window
    input wire logic cyc_retry_i,                // engine: cycle being retried
    input wire logic cyc_end_i,                  // engine: cycle end pulse
    input wire logic operand_end_i,              // engine: last piece of operand
    input wire logic xfer_end_i,                 // engine: normal count completion
    input wire logic ext_req_i,                  // external request, recognised
    input wire logic arb_step_i,                 // bus slot free: re-arbitrate
    input wire logic [NPEER-1:0] peer_req_i,     // peer channel requests
    input wire logic [2*NPEER-1:0] peer_pri_i,   // peer priorities
    output logic [NPEER:0] grant_o,              // one-hot grant, bit 0 own
    output logic req_o                           // own request pending
);
    import dch_pkg::*;
    localparam int NCH = NPEER + 1;
    localparam int IW = $clog2(NCH);
    if (NPEER < 1 || NPEER > 7) begin : g_npeer_chk
        $error("NPEER out of range");
    end
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] devctl_ff, opctl_ff, genctl_ff, prio_ff;
    logic [4:0] err_ff;
    logic pct_ff, coc_ff, ndt_ff, start_ff;
    dch_state_type state_ff, nxt_state;
    logic pcl_s1_ff, pcl_s2_ff, done_s1_ff, done_s2_ff, bg_s1_ff, bg_s2_ff;
    logic [1:0] own_done_ff;
    logic [2:0] hist_ff;
    logic [2:0] pulse_ff;
    logic pulse_on;
    dch_dtype_type dtype;
    dch_pfunc_type pfunc;
    dch_request_generation_field_type request_generation_field;
    assign dtype = dch_dtype_type'(devctl_ff[`DCH_DT_POS +: 2]);
    assign pfunc = dch_pfunc_type'(devctl_ff[`DCH_FN_POS +: 3]);
    assign request_generation_field = dch_request_generation_field_type'(opctl_ff[`DCH_RQ_POS +: 2]);
    logic wr_dev, wr_op, wr_ch, wr_st, wr_gen, wr_pri;
    assign wr_dev = reg_wr_i && reg_addr_i == `DCH_OFF_DEVCTL;
    assign wr_op = reg_wr_i && reg_addr_i == `DCH_OFF_OPCTL;
    assign wr_ch = reg_wr_i && reg_addr_i == `DCH_OFF_CHCTL;
    assign wr_st = reg_wr_i && reg_addr_i == `DCH_OFF_STATUS;
    assign wr_gen = reg_wr_i && reg_addr_i == `DCH_OFF_GENCTL;
    assign wr_pri = reg_wr_i && reg_addr_i == `DCH_OFF_PRIO;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            devctl_ff <= `DCH_RST_REG;
            opctl_ff <= `DCH_RST_REG;
            genctl_ff <= `DCH_RST_REG;
            prio_ff <= `DCH_RST_REG;
        end else begin
            if (wr_dev) devctl_ff <= {2'h0, reg_wdata_i[5:4], 1'b0, reg_wdata_i[2:0]};
            if (wr_op) opctl_ff <= {3'h0, reg_wdata_i[4:0]};
            if (wr_gen) genctl_ff <= {4'h0, reg_wdata_i[3:0]};
            if (wr_pri) prio_ff <= {6'h00, reg_wdata_i[1:0]};
        end
    end
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // two flops per pin
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pcl_s1_ff <= 1'b1;
            pcl_s2_ff <= 1'b1;
            done_s1_ff <= 1'b1;
            done_s2_ff <= 1'b1;
            bg_s1_ff <= 1'b1;
            bg_s2_ff <= 1'b1;
            hist_ff <= 3'h7;
            own_done_ff <= 2'h0;
        end else begin
            pcl_s1_ff <= pcl_n_i;
            pcl_s2_ff <= pcl_s1_ff;
            done_s1_ff <= done_n_i;
            done_s2_ff <= done_s1_ff;
            bg_s1_ff <= bus_grant_acknowledge_n_i;
            bg_s2_ff <= bg_s1_ff;
            hist_ff <= {hist_ff[1:0], pcl_s2_ff};
            own_done_ff <= {own_done_ff[0], done_oe_o};
        end
    end
    // ----------------------------------------
    // control line functions
    // ----------------------------------------
    logic pct_set, sync_type, rdy_type;
    // high then stable low two clocks
    assign pct_set = hist_ff == 3'b100;
    assign sync_type = dtype == DT_SYNC8;
    assign rdy_type = dtype == DT_ACK_RDY;
    assign eclk_rise_o = sync_type && hist_ff[0] && !hist_ff[1];
    assign eclk_fall_o = sync_type && !hist_ff[0] && hist_ff[1];
    assign ready_o = rdy_type && !pcl_s2_ff;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pct_ff <= 1'b0;
        end else if (pct_set) begin
            pct_ff <= 1'b1;
        end else if (wr_st && reg_wdata_i[`DCH_ST_PCT]) begin
            pct_ff <= 1'b0;
        end
    end
    logic func_live;
    assign func_live = !sync_type && !rdy_type;
    assign irq_o = func_live && pfunc == FN_IRQ && pct_ff;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pulse_ff <= 3'h0;
        end else if (start_ff && func_live && pfunc == FN_START) begin
            pulse_ff <= `DCH_START_CYC;
        end else if (pulse_ff != 3'h0) begin
            pulse_ff <= pulse_ff - 3'h1;
        end
    end
    assign pulse_on = pulse_ff != 3'h0;
    assign pcl_n_o = 1'b0;
    assign pcl_oe_o = pulse_on;
    // ----------------------------------------
    // channel state and termination
    // ----------------------------------------
    logic activate, abort_hit, dev_done, final_xfer, term_done, ack_live, m2m_auto, auto_rq;
    dch_blk_type blk;
    assign blk = dch_blk_type'(opctl_ff[`DCH_BLK_POS +: 2]);
    assign activate = wr_ch && reg_wdata_i[`DCH_ACT_POS] && state_ff == ST_IDLE;
    assign abort_hit = func_live && pfunc == FN_ABORT && pct_ff && state_ff != ST_IDLE;
    // peripheral done during acknowledge; own drive masked with the same sync lag
    assign dev_done = !done_s2_ff && !ack_n_o && !own_done_ff[1];
    assign term_done = (state_ff == ST_STOP || dev_done) && cyc_end_i && operand_end_i;
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (activate) nxt_state = ST_RUN;
            end
            ST_RUN: begin
                if (abort_hit || xfer_end_i) nxt_state = ST_IDLE;
                else if (term_done) nxt_state = ST_IDLE;
                else if (dev_done) nxt_state = ST_STOP;
            end
            ST_STOP: begin
                if (abort_hit || term_done) nxt_state = ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_ff <= ST_IDLE;
            start_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            start_ff <= activate;
        end
    end
    // done termination status; set wins over clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            coc_ff <= 1'b0;
            ndt_ff <= 1'b0;
            err_ff <= 5'h00;
        end else begin
            if (state_ff != ST_IDLE && nxt_state == ST_IDLE) coc_ff <= 1'b1;
            else if (wr_st && reg_wdata_i[`DCH_ST_COC]) coc_ff <= 1'b0;
            if (term_done && !abort_hit) ndt_ff <= 1'b1;
            else if (wr_st && reg_wdata_i[`DCH_ST_NDT]) ndt_ff <= 1'b0;
            if (abort_hit) err_ff <= `DCH_ERR_EXT_ABORT;
            else if (activate) err_ff <= 5'h00;
        end
    end
    // ----------------------------------------
    // acknowledge, done and strobe outputs
    // ----------------------------------------
    assign auto_rq = request_generation_field == RQ_LIMITED || request_generation_field == RQ_MAXRATE;
    assign m2m_auto = auto_rq && opctl_ff[`DCH_M2M_POS];
    // acknowledge hidden for auto-request 16-bit type and memory-to-memory
    assign ack_live = cyc_dev_i && state_ff != ST_IDLE && !m2m_auto && !(auto_rq && dtype == DT_ASYNC16);
    assign ack_n_o = !ack_live;
    assign high_byte_indicator_n_o = !(cyc_high_byte_indicator_i && cyc_dev_i && !m2m_auto);
    always_comb begin
        case (blk)
            BLK_CHAIN: final_xfer = cyc_mtc_last_i && cyc_btc_last_i;
            default: final_xfer = cyc_mtc_last_i;
        endcase
    end
    // done rides with acknowledge; retry keeps it for the repeat
    assign done_oe_o = ack_live && final_xfer && (!cyc_exc_i || cyc_retry_i);
    assign done_n_o = 1'b0;
    assign dtc_n_o = !(cyc_strobe_i && cyc_data_i && !cyc_exc_i && state_ff != ST_IDLE);
    // ----------------------------------------
    // limited-rate sample intervals
    // ----------------------------------------
    logic [11:0] samp_ff, busy_ff, int_len, win_len;
    logic allow_ff, samp_end, in_window;
    assign int_len = 12'h001 << ({2'h0, genctl_ff[`DCH_BT_POS +: 2]} + {2'h0, genctl_ff[`DCH_BR_POS +: 2]} + 4'h5);
    assign win_len = 12'h001 << (genctl_ff[`DCH_BT_POS +: 2] + 3'h4);
    assign samp_end = samp_ff >= int_len - 12'h001;
    assign in_window = samp_ff < win_len;
    // free running interval with busy count
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            samp_ff <= 12'h000;
            busy_ff <= 12'h000;
            allow_ff <= 1'b0;
        end else if (samp_end) begin
            samp_ff <= 12'h000;
            busy_ff <= 12'h000;
            // busy share above window length blocks next interval
            allow_ff <= (busy_ff + {11'h000, !bg_s2_ff}) <= win_len;
        end else begin
            samp_ff <= samp_ff + 12'h001;
            busy_ff <= busy_ff + {11'h000, !bg_s2_ff};
        end
    end
    always_comb begin
        case (request_generation_field)
            RQ_MAXRATE: req_o = state_ff == ST_RUN;
            RQ_LIMITED: req_o = state_ff == ST_RUN && allow_ff && in_window;
            default: req_o = state_ff == ST_RUN && ext_req_i;
        endcase
    end
    // ----------------------------------------
    // priority arbitration
    // ----------------------------------------
    logic [NCH-1:0] req_vec;
    logic [2*NCH-1:0] pri_vec;
    logic [IW-1:0] rr_ff, win_idx, idx;
    logic [1:0] best;
    logic found;
    assign req_vec = {peer_req_i, req_o};
    assign pri_vec = {peer_pri_i, prio_ff[1:0]};
    // lowest number wins; rotation among equals
    always_comb begin
        best = 2'h3;
        found = 1'b0;
        win_idx = '0;
        idx = '0;
        for (int i = 0; i < NCH; i++) begin
            if (req_vec[i] && pri_vec[2*i +: 2] < best) best = pri_vec[2*i +: 2];
        end
        for (int k = 1; k <= NCH; k++) begin
            idx = IW'((int'(rr_ff) + k) % NCH);
            if (!found && req_vec[idx] && pri_vec[2*idx +: 2] == best) begin
                found = 1'b1;
                win_idx = idx;
            end
        end
    end
    // regrant each free slot so higher priority preempts
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rr_ff <= '0;
            grant_o <= '0;
        end else if (arb_step_i) begin
            grant_o <= found ? (NCH'(1) << win_idx) : '0;
            if (found) rr_ff <= win_idx;
        end
    end
    // ----------------------------------------
    // register read
    // ----------------------------------------
    // level bit from synchronised line
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `DCH_OFF_DEVCTL: reg_rdata_o <= devctl_ff;
                `DCH_OFF_OPCTL: reg_rdata_o <= opctl_ff;
                `DCH_OFF_STATUS: reg_rdata_o <= {3'h0, !pcl_s2_ff, pct_ff, ndt_ff, coc_ff, state_ff != ST_IDLE};
                `DCH_OFF_ERROR: reg_rdata_o <= {3'h0, err_ff};
                `DCH_OFF_GENCTL: reg_rdata_o <= genctl_ff;
                `DCH_OFF_PRIO: reg_rdata_o <= prio_ff;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_level_bit: assert property (@(posedge clk_i) disable iff (reset_i)
        reg_rd_i && reg_addr_i == `DCH_OFF_STATUS |=> reg_rdata_o[`DCH_ST_PCS] == !$past(pcl_s2_ff))
        else $error("status level bit wrong");
    a_flag_set: assert property (@(posedge clk_i) disable iff (reset_i)
        $fell(pcl_s2_ff) ##1 !pcl_s2_ff ##1 !pcl_s2_ff |=> pct_ff) else $error("transition flag not set");
    a_irq_flag: assert property (@(posedge clk_i) disable iff (reset_i)
        pct_ff && func_live && pfunc == FN_IRQ |-> irq_o) else $error("interrupt missing");
    a_start_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
        activate && func_live && pfunc == FN_START && !wr_dev |=> ##1 pcl_oe_o[*4] ##1 !pcl_oe_o)
        else $error("start pulse not four clocks");
    a_abort_code: assert property (@(posedge clk_i) disable iff (reset_i)
        abort_hit |=> state_ff == ST_IDLE && err_ff == `DCH_ERR_EXT_ABORT) else $error("abort not recorded");
    a_done_ack: assert property (@(posedge clk_i) disable iff (reset_i)
        done_oe_o |-> !ack_n_o) else $error("done without acknowledge");
    a_done_term: assert property (@(posedge clk_i) disable iff (reset_i)
        term_done && !abort_hit |=> state_ff == ST_IDLE && coc_ff && ndt_ff) else $error("done termination wrong");
    a_strobe_exc: assert property (@(posedge clk_i) disable iff (reset_i)
        cyc_exc_i |-> dtc_n_o) else $error("strobe in exception cycle");
    a_rate_window: assert property (@(posedge clk_i) disable iff (reset_i)
        req_o && request_generation_field == RQ_LIMITED |-> samp_ff < win_len && allow_ff) else $error("limited request outside window");
    a_m2m_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
        m2m_auto |-> ack_n_o && high_byte_indicator_n_o && !done_oe_o) else $error("memory-to-memory outputs active");
endmodule
`default_nettype wire

// file: common/dch_params.svh
// constants of the dma channel request and device signal block
// assumes inclusion by the package and by the channel module
`ifndef DCH_PARAMS_SVH
`define DCH_PARAMS_SVH
`define DCH_OFF_DEVCTL 3'h0
`define DCH_OFF_OPCTL 3'h1
`define DCH_OFF_CHCTL 3'h2
`define DCH_OFF_STATUS 3'h3
`define DCH_OFF_ERROR 3'h4
`define DCH_OFF_GENCTL 3'h5
`define DCH_OFF_PRIO 3'h6
`define DCH_DT_POS 4
`define DCH_FN_POS 0
`define DCH_RQ_POS 0
`define DCH_M2M_POS 2
`define DCH_BLK_POS 3
`define DCH_ACT_POS 0
`define DCH_BR_POS 0
`define DCH_BT_POS 2
`define DCH_ST_ACT 0
`define DCH_ST_COC 1
`define DCH_ST_NDT 2
`define DCH_ST_PCT 3
`define DCH_ST_PCS 4
`define DCH_RST_REG 8'h00
`define DCH_ERR_EXT_ABORT 5'h10
`define DCH_START_CYC 3'h4
`define DCH_FALL_STABLE 2
`endif

// file: common/dch_pkg.sv
// types of the dma channel request and device signal block
// assumes the params header sits beside it
`include "dch_params.svh"
package dch_pkg;
    typedef enum logic [1:0] {
        DT_ASYNC16 = 2'h0,
        DT_SYNC8 = 2'h1,
        DT_ACK = 2'h2,
        DT_ACK_RDY = 2'h3
    } dch_dtype_type;
    typedef enum logic [2:0] {
        FN_STATUS = 3'h0,
        FN_IRQ = 3'h1,
        FN_START = 3'h2,
        FN_ABORT = 3'h3
    } dch_pfunc_type;
    typedef enum logic [1:0] {
        RQ_LIMITED = 2'h0,
        RQ_MAXRATE = 2'h1,
        RQ_EXT = 2'h2,
        RQ_MIXED = 2'h3
    } dch_request_generation_field_type;
    typedef enum logic [1:0] {
        BLK_SINGLE = 2'h0,
        BLK_CHAIN = 2'h1,
        BLK_CONT = 2'h2
    } dch_blk_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_STOP = 3'b100
    } dch_state_type;
endpackage

// file: sim/dch_periph_model.sv
// peripheral model: pulls the control line low or makes the enable clock
// assumes the bench resolves the open-drain line with a pull-up
`timescale 1ns/10ps
`default_nettype none
module dch_periph_model (
    input wire logic eclk_mode_i, // make enable clock on the line
    input wire logic pcl_low_i,   // bench asks for the line low
    output logic pcl_low_o        // model pulls the line low
);
    logic e_clk = 1'b1;
    // low 250 ns, high 150 ns, own phase
    initial begin
        #13;
        forever begin
            if (eclk_mode_i) begin
                e_clk = 1'b0;
            end
            #250;
            e_clk = 1'b1;
            #150;
        end
    end
    assign pcl_low_o = eclk_mode_i ? !e_clk : pcl_low_i;
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench of one dma channel with a peripheral model
// assumes package and peripheral model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import dch_pkg::*;
    logic clk_i = 0, reset_i = 1, reg_wr_i = 0, reg_rd_i = 0;
    logic [2:0] reg_addr_i = 0, peer_req_i = 0;
    logic [7:0] reg_wdata_i = 0, reg_rdata_o;
    logic [5:0] peer_pri_i = 0;
    logic [3:0] grant_o, xg;
    logic dev = 0, hb = 0, last = 0, btc = 0, dat = 0, exc = 0, stb = 0, cend = 0, oend = 0, xend = 0;
    logic arb = 0, bus_grant_acknowledge = 1, emode = 0, plow = 0, dlow = 0, mlow, pcl_oe_o, done_oe_o;
    logic ack_n_o, high_byte_indicator_n_o, dtc_n_o, irq_o, erise, req_o, rdy;
    int mismatches = 0, num_checks = 0, seed = 52, last_w = 0, n;
    dch_periph_model u_per (.eclk_mode_i(emode), .pcl_low_i(plow), .pcl_low_o(mlow));
    dch_channel u_dut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pcl_n_i(!(pcl_oe_o | mlow)),
        .pcl_n_o(), .pcl_oe_o(pcl_oe_o), .done_n_i(!(done_oe_o | dlow)), .done_n_o(), .done_oe_o(done_oe_o),
        .bus_grant_acknowledge_n_i(bus_grant_acknowledge), .ack_n_o(ack_n_o), .high_byte_indicator_n_o(high_byte_indicator_n_o), .dtc_n_o(dtc_n_o), .irq_o(irq_o),
        .eclk_rise_o(erise), .eclk_fall_o(), .ready_o(rdy), .cyc_dev_i(dev), .cyc_high_byte_indicator_i(hb),
        .cyc_mtc_last_i(last), .cyc_btc_last_i(btc), .cyc_data_i(dat), .cyc_exc_i(exc), .cyc_strobe_i(stb),
        .cyc_retry_i(1'b0), .cyc_end_i(cend), .operand_end_i(oend), .xfer_end_i(xend), .ext_req_i(1'b0),
        .arb_step_i(arb), .peer_req_i(peer_req_i), .peer_pri_i(peer_pri_i), .grant_o(grant_o), .req_o(req_o));
    initial begin
        forever #25 clk_i = !clk_i;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic w(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk("reg", e, reg_rdata_o);
    endtask
    task automatic pulse_end();
        @(posedge clk_i);
        xend <= 1'b1;
        @(posedge clk_i);
        xend <= 1'b0;
        wr(3, 8'h0e);
    endtask
    // expected grant: lowest level wins, ties go to first after last winner
    function automatic logic [3:0] exp_g(input logic [3:0] rq, input logic [7:0] p);
        int b = 4;
        for (int k = 1; k <= 4; k++) begin
            if (rq[(last_w + k) % 4] && (b == 4 || p[2*((last_w+k)%4)+:2] < p[2*b+:2])) b = (last_w + k) % 4;
        end
        if (b != 4) last_w = b;
        return (b == 4) ? 4'h0 : 4'(1 << b);
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        conclude();
    end
    initial begin
        w(5);
        reset_i <= 1'b0;
        rdc(3, 8'h00);
        rdc(7, 8'h00);
        plow <= 1'b1;
        w(1);
        plow <= 1'b0;
        w(5);
        rdc(3, 8'h00);
        plow <= 1'b1;
        w(5);
        rdc(3, 8'h18);
        plow <= 1'b0;
        w(4);
        rdc(3, 8'h08);
        wr(3, 8'h08);
        wr(0, 8'h01);
        chk("irq", 0, irq_o);
        plow <= 1'b1;
        w(5);
        chk("irq", 1, irq_o);
        plow <= 1'b0;
        wr(3, 8'h08);
        $display("line flag test done");
        wr(0, 8'h02);
        wr(2, 8'h01);
        n = 0;
        repeat (12) begin
            w(1);
            n += pcl_oe_o;
        end
        chk("start_len", 4, n[7:0]);
        pulse_end();
        wr(0, 8'h03);
        wr(2, 8'h01);
        rdc(3, 8'h01);
        plow <= 1'b1;
        w(6);
        rdc(3, 8'h1a);
        rdc(4, 8'h10);
        plow <= 1'b0;
        wr(3, 8'h0e);
        wr(0, 8'h10);
        emode <= 1'b1;
        w(20);
        n = 0;
        repeat (80) begin
            w(1);
            n += erise;
        end
        chk("eclk_rises", 10, n[7:0]);
        emode <= 1'b0;
        wr(0, 8'h30);
        plow <= 1'b1;
        w(4);
        chk("ready", 1, rdy);
        plow <= 1'b0;
        w(8);
        chk("ready", 0, rdy);
        wr(3, 8'h0e);
        $display("pulse abort eclk test done");
        wr(0, 8'h20);
        wr(1, 8'h02);
        wr(2, 8'h01);
        repeat (40) begin
            @(posedge clk_i);
            {dev, last, exc, dat, stb, hb, btc} <= 7'($random(seed));
            #1;
            chk("ack", !dev, ack_n_o);
            chk("done", dev & last & !exc, done_oe_o);
            chk("dtc", !(dat & stb & !exc), dtc_n_o);
        end
        {dev, last, exc, dat, stb, hb} <= 6'h20;
        dlow <= 1'b1;
        w(4);
        cend <= 1'b1;
        w(1);
        cend <= 1'b0;
        rdc(3, 8'h01);
        {cend, oend} <= 2'h3;
        w(1);
        {cend, oend, dlow} <= 3'h0;
        rdc(3, 8'h06);
        wr(3, 8'h0e);
        wr(1, 8'h05);
        wr(2, 8'h01);
        last <= 1'b1;
        w(2);
        chk("m2m", 8'h3, {!ack_n_o, high_byte_indicator_n_o, !done_oe_o});
        {dev, last} <= 2'h0;
        pulse_end();
        $display("done strobe test done");
        wr(1, 8'h01);
        wr(6, 8'h02);
        wr(2, 8'h01);
        w(1);
        chk("req", 1, req_o);
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_i);
            arb <= 1'b1;
            peer_req_i <= (i == 0) ? 3'h0 : 3'($random(seed));
            peer_pri_i <= 6'($random(seed));
            bus_grant_acknowledge <= 1'($random(seed));
            @(posedge clk_i);
            arb <= 1'b0;
            xg = exp_g({peer_req_i, 1'b1}, {peer_pri_i, 2'h2});
            #1 chk("grant", xg, grant_o);
        end
        $display("arbiter test done");
        pulse_end();
        wr(5, 8'h03);
        wr(1, 8'h00);
        wr(2, 8'h01);
        bus_grant_acknowledge <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            w(600);
            n = 0;
            repeat (256) begin
                w(1);
                n += req_o;
            end
            chk("lim_req", p ? 0 : 16, n[7:0]);
            bus_grant_acknowledge <= 1'b0;
        end
        $display("limited rate test done");
        conclude();
    end
endmodule
`default_nettype wire
